// ===== rtl/charge_time_pkg.sv
package charge_time_pkg;

  // register indices on the plain port (no offsets are printed)
  localparam logic [3:0] ADDR_CURRENT_CTRL = 4'h0;
  localparam logic [3:0] ADDR_EDGE_CFG = 4'h1;
  localparam logic [3:0] ADDR_MODULE_CTRL = 4'h2;
  localparam logic [3:0] ADDR_FLAG = 4'h3;
  localparam logic [3:0] ADDR_INT_ENABLE = 4'h4;

  // reset values
  localparam logic [7:0] RST_CURRENT_CTRL = 8'h00;
  localparam logic [7:0] RST_EDGE_CFG = 8'h00;
  localparam logic [7:0] RST_MODULE_CTRL = 8'h00;

  // current control fields
  localparam int RANGE_LSB = 0;
  localparam int TRIM_LSB = 2;

  // edge configuration fields
  localparam int STAT_ONE_BIT = 0;
  localparam int STAT_TWO_BIT = 1;
  localparam int SEL_ONE_LSB = 2;
  localparam int POL_ONE_BIT = 4;
  localparam int SEL_TWO_LSB = 5;
  localparam int POL_TWO_BIT = 7;

  // module control fields
  localparam int TDLY_BIT = 0;
  localparam int DISCH_BIT = 1;
  localparam int SEQ_BIT = 2;
  localparam int EDGE_INPUTS_ENABLE_BIT = 3;
  localparam int MODEN_BIT = 7;

  // flag and enable registers
  localparam int FLAG_BIT = 2;

  // edge source codes
  typedef enum logic [1:0] {
    SRC_PIN_ONE = 2'b00,
    SRC_PIN_TWO = 2'b01,
    SRC_TRIG_ONE = 2'b10,
    SRC_TRIG_TWO = 2'b11
  } edge_src_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic [1:0] range;
    logic [5:0] trim;
    logic currentOn;
    logic discharge;
    logic timeDelayMode;
    logic toComparatorInput;
  } analog_ctl_t;

endpackage : charge_time_pkg

// ===== rtl/charge_time_edge_control.sv
// How it works
// - two-bit range, code 00 lowest
// - six-bit trim in bits seven to two
// - each channel picks one of four sources
// - channels respond to level, not transitions
// - per-channel polarity bits seven and four
// - sequencing: edge two only after one
// - hardware sets status on edge response
// - matching configuration sets status immediately
// - current on when exactly one status set
// - software may set or clear status bits
// - flag set when current goes off
// - interrupt only when flag and enable
// - reset polarity is negative on both
// - reset leaves sequencing disabled
// - mode bit, measurement after reset
// - time delay routes current to comparator
// - discharge driven from control bit one
// - module enable gates current, discharge and comparator routing
// - edges accepted only with edge enable
`timescale 1ns/10ps
module charge_time_edge_control (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // register port
  input wire charge_time_pkg::reg_req_t regReq,
  output logic [7:0] regRdata,
  // edge sources
  input wire logic edgePinOne,
  input wire logic edgePinTwo,
  input wire logic trigOne,
  input wire logic trigTwo,
  // analog control and interrupt
  output charge_time_pkg::analog_ctl_t analogCtl,
  output logic irqReq
);

  logic [7:0] curCtl_q;
  logic [7:0] edgeCfg_q;
  logic [7:0] modCtl_q;
  logic flag_q;
  logic intEn_q;
  logic currentOn_q;
  logic [7:0] rdata_q;
  logic [2:0] pinOneSync_q;
  logic [2:0] pinTwoSync_q;
  logic pinOne_q;
  logic pinTwo_q;

  // pins cross in from outside: three stages, stage two and three agree
  always_ff @(posedge clk) begin
    if (srst) begin
      pinOneSync_q <= 3'h0;
      pinTwoSync_q <= 3'h0;
      pinOne_q <= 1'b0;
      pinTwo_q <= 1'b0;
    end else begin
      pinOneSync_q <= {pinOneSync_q[1:0], edgePinOne};
      pinTwoSync_q <= {pinTwoSync_q[1:0], edgePinTwo};
      if (pinOneSync_q[1] == pinOneSync_q[2]) begin
        pinOne_q <= pinOneSync_q[2];
      end
      if (pinTwoSync_q[1] == pinTwoSync_q[2]) begin
        pinTwo_q <= pinTwoSync_q[2];
      end
    end
  end

  // decode
  wire wrCur = regReq.wr && regReq.addr == charge_time_pkg::ADDR_CURRENT_CTRL;
  wire wrEdge = regReq.wr && regReq.addr == charge_time_pkg::ADDR_EDGE_CFG;
  wire wrMod = regReq.wr && regReq.addr == charge_time_pkg::ADDR_MODULE_CTRL;
  wire wrFlag = regReq.wr && regReq.addr == charge_time_pkg::ADDR_FLAG;
  wire wrIntEn = regReq.wr && regReq.addr == charge_time_pkg::ADDR_INT_ENABLE;

  // effective configuration: a pending write takes effect same cycle
  wire [7:0] cfgNow = wrEdge ? regReq.wdata : edgeCfg_q;
  wire [1:0] selOne = cfgNow[charge_time_pkg::SEL_ONE_LSB +: 2];
  wire [1:0] selTwo = cfgNow[charge_time_pkg::SEL_TWO_LSB +: 2];
  wire polOne = cfgNow[charge_time_pkg::POL_ONE_BIT];
  wire polTwo = cfgNow[charge_time_pkg::POL_TWO_BIT];
  wire modEn = modCtl_q[charge_time_pkg::MODEN_BIT];
  // module enable as it will stand after this edge
  wire [7:0] modCtlNow = wrMod ? regReq.wdata : modCtl_q;
  wire modEnNext = modCtlNow[charge_time_pkg::MODEN_BIT];
  wire edgeEn = modCtl_q[charge_time_pkg::EDGE_INPUTS_ENABLE_BIT];
  wire seqEn = modCtl_q[charge_time_pkg::SEQ_BIT];
  wire statOne = edgeCfg_q[charge_time_pkg::STAT_ONE_BIT];
  wire statTwo = edgeCfg_q[charge_time_pkg::STAT_TWO_BIT];

  wire [3:0] srcVec = {trigTwo, trigOne, pinTwo_q, pinOne_q};
  wire rawOne = srcVec[selOne];
  wire rawTwo = srcVec[selTwo];

  // level after polarity; polarity 0 means active low
  wire lvlOne = polOne ? rawOne : ~rawOne;
  wire lvlTwo = polTwo ? rawTwo : ~rawTwo;

  // edges gated by module and edge enable
  wire hitOne = modEn && edgeEn && lvlOne;
  // edge two needs edge one first when sequencing
  wire hitTwo = modEn && edgeEn && lvlTwo && (!seqEn || statOne);

  // software write value of status bits
  wire swOne = wrEdge ? regReq.wdata[charge_time_pkg::STAT_ONE_BIT] : statOne;
  wire swTwo = wrEdge ? regReq.wdata[charge_time_pkg::STAT_TWO_BIT] : statTwo;
  wire nextOne = swOne | hitOne;
  wire nextTwo = swTwo | hitTwo;
  wire [7:0] edgeCfg_d = {cfgNow[7:2], nextTwo, nextOne};

  // exactly one status bit enables current
  // next enable, so a disable write cuts the current on the same edge
  wire currentOn_d = modEnNext && (nextOne ^ nextTwo);
  wire offEvent = currentOn_q && !currentOn_d;

  // reset values clear pol, seq, mode
  always_ff @(posedge clk) begin
    if (srst) begin
      curCtl_q <= charge_time_pkg::RST_CURRENT_CTRL;
      edgeCfg_q <= charge_time_pkg::RST_EDGE_CFG;
      modCtl_q <= charge_time_pkg::RST_MODULE_CTRL;
      currentOn_q <= 1'b0;
    end else begin
      if (wrCur) begin
        curCtl_q <= regReq.wdata;
      end
      if (wrMod) begin
        modCtl_q <= regReq.wdata;
      end
      edgeCfg_q <= edgeCfg_d;
      currentOn_q <= currentOn_d;
    end
  end

  // flag set wins over software clear
  always_ff @(posedge clk) begin
    if (srst) begin
      flag_q <= 1'b0;
      intEn_q <= 1'b0;
    end else begin
      flag_q <= offEvent | (wrFlag ? regReq.wdata[charge_time_pkg::FLAG_BIT]
                                   : flag_q);
      if (wrIntEn) begin
        intEn_q <= regReq.wdata[charge_time_pkg::FLAG_BIT];
      end
    end
  end

  assign irqReq = flag_q && intEn_q;

  // read mux, unmapped reads zero
  logic [7:0] rdMux;
  always_comb begin
    unique case (regReq.addr)
      charge_time_pkg::ADDR_CURRENT_CTRL: rdMux = curCtl_q;
      charge_time_pkg::ADDR_EDGE_CFG: rdMux = edgeCfg_q;
      charge_time_pkg::ADDR_MODULE_CTRL: rdMux = modCtl_q;
      charge_time_pkg::ADDR_FLAG: rdMux = {5'h00, flag_q, 2'h0};
      charge_time_pkg::ADDR_INT_ENABLE: rdMux = {5'h00, intEn_q, 2'h0};
      default: rdMux = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= regReq.rd ? rdMux : 8'h00;
    end
  end
  assign regRdata = rdata_q;

  assign analogCtl.range = curCtl_q[charge_time_pkg::RANGE_LSB +: 2];
  assign analogCtl.trim = curCtl_q[charge_time_pkg::TRIM_LSB +: 6];
  assign analogCtl.currentOn = currentOn_q;
  assign analogCtl.discharge = modEn && modCtl_q[charge_time_pkg::DISCH_BIT];
  assign analogCtl.timeDelayMode = modCtl_q[charge_time_pkg::TDLY_BIT];
  assign analogCtl.toComparatorInput =
    modEn && modCtl_q[charge_time_pkg::TDLY_BIT];

  // checks
  AST_CUR_XOR: assert property (@(posedge clk) disable iff (srst)
    currentOn_q == (modEn && (statOne ^ statTwo)))
    else $error("current enable not exactly-one status");
  AST_FLAG_OFF: assert property (@(posedge clk) disable iff (srst)
    offEvent |=> flag_q)
    else $error("flag not set on current off");
  AST_IRQ: assert property (@(posedge clk) disable iff (srst)
    (offEvent && intEn_q && !wrIntEn) |=> irqReq)
    else $error("interrupt not raised on enabled flag");
  AST_IRQ_OFF: assert property (@(posedge clk) disable iff (srst)
    (!intEn_q && !wrIntEn) |=> !irqReq)
    else $error("interrupt raised while disabled");
  AST_SEQ: assert property (@(posedge clk) disable iff (srst)
    (seqEn && !statOne && !statTwo && !wrEdge && !hitOne) |=> !statTwo)
    else $error("edge two accepted before edge one");
  AST_NO_EDGE: assert property (@(posedge clk) disable iff (srst)
    (!edgeEn && !wrEdge && !wrMod && !statOne) |=> !statOne)
    else $error("status set with edges disabled");
  AST_HW_WINS: assert property (@(posedge clk) disable iff (srst)
    hitOne |=> statOne)
    else $error("hardware set lost");
  AST_SW_SET: assert property (@(posedge clk) disable iff (srst)
    (wrEdge && regReq.wdata[1:0] == 2'b01 && modEn && !wrMod
      && !hitTwo) |=> currentOn_q)
    else $error("software set did not start current");
  AST_RESET: assert property (@(posedge clk)
    ($past(srst) && !srst) |-> (!polOne && !polTwo) && !seqEn
      && !analogCtl.timeDelayMode)
    else $error("bad reset configuration");
  AST_SW_BOTH: assert property (@(posedge clk) disable iff (srst)
    (wrEdge && regReq.wdata[1:0] == 2'b11) |=> statOne && statTwo
      && !currentOn_q)
    else $error("both status bits did not stop current");
  AST_SW_CLEAR: assert property (@(posedge clk) disable iff (srst)
    (wrEdge && regReq.wdata[1:0] == 2'b00 && !hitOne && !hitTwo)
      |=> !statOne && !statTwo)
    else $error("status bits not cleared by write");
  AST_MATCH: assert property (@(posedge clk) disable iff (srst)
    (wrEdge && modEn && edgeEn && lvlTwo && !seqEn) |=> statTwo)
    else $error("matching configuration did not set status");
  AST_SRC_TRIG: assert property (@(posedge clk) disable iff (srst)
    (modEn && edgeEn && !wrEdge && selOne == 2'b10 && polOne && trigOne)
      |=> statOne)
    else $error("trigger source not selected");
  AST_FLAG_HOLD: assert property (@(posedge clk) disable iff (srst)
    (flag_q && !wrFlag) |=> flag_q)
    else $error("flag lost without a clear");
  AST_MOD_OFF: assert property (@(posedge clk) disable iff (srst)
    (wrMod && !regReq.wdata[7]) |=> !analogCtl.currentOn
      && !analogCtl.discharge && !analogCtl.toComparatorInput)
    else $error("module disable did not gate outputs");
  AST_DISCH: assert property (@(posedge clk) disable iff (srst)
    (wrMod && regReq.wdata[7] && regReq.wdata[1]) |=> analogCtl.discharge)
    else $error("discharge not driven");
  AST_TDLY: assert property (@(posedge clk) disable iff (srst)
    (wrMod && regReq.wdata[7] && regReq.wdata[0])
      |=> analogCtl.toComparatorInput && analogCtl.timeDelayMode)
    else $error("time delay routing missing");
  AST_TRIM: assert property (@(posedge clk) disable iff (srst)
    wrCur |=> {analogCtl.trim, analogCtl.range} == $past(regReq.wdata))
    else $error("current control not applied");
  AST_SYNC: assert property (@(posedge clk) disable iff (srst)
    (pinOne_q != $past(pinOne_q))
      |-> $past(pinOneSync_q[1]) == $past(pinOneSync_q[2]))
    else $error("pin accepted before stages agree");
  AST_RDATA_IDLE: assert property (@(posedge clk) disable iff (srst)
    !regReq.rd |=> regRdata == 8'h00)
    else $error("read data outside its cycle");
  COV_MEAS: cover property (@(posedge clk) disable iff (srst)
    currentOn_q ##[1:20] offEvent);
  COV_SEQ: cover property (@(posedge clk) disable iff (srst)
    seqEn && hitTwo);
  COV_IRQ: cover property (@(posedge clk) disable iff (srst) $rose(irqReq));
  COV_MATCH: cover property (@(posedge clk) disable iff (srst)
    wrEdge && hitOne);

endmodule : charge_time_edge_control

// ===== test/edge_source_model.sv
`timescale 1ns/10ps
module edge_source_model (
  // clock
  input wire logic clk,
  // requested levels: pin one, pin two, trigger one, trigger two
  input wire logic [3:0] want,
  // edge sources
  output logic edgePinOne,
  output logic edgePinTwo,
  output logic trigOne,
  output logic trigTwo
);
  // pins change off the clock grid, so the synchroniser is exercised
  initial begin
    edgePinOne = 1'b0;
    edgePinTwo = 1'b0;
    trigOne = 1'b0;
    trigTwo = 1'b0;
    forever begin
      @(want);
      #17;
      edgePinOne = want[0];
      edgePinTwo = want[1];
    end
  end
  always @(posedge clk) begin
    trigOne <= want[2];
    trigTwo <= want[3];
  end
endmodule : edge_source_model

// ===== test/charge_time_edge_control_tb_top.sv
`timescale 1ns/10ps
module charge_time_edge_control_tb_top;
  localparam logic [3:0] CUR = charge_time_pkg::ADDR_CURRENT_CTRL;
  localparam logic [3:0] CFG = charge_time_pkg::ADDR_EDGE_CFG;
  localparam logic [3:0] MOD = charge_time_pkg::ADDR_MODULE_CTRL;
  localparam logic [3:0] FLG = charge_time_pkg::ADDR_FLAG;
  localparam logic [3:0] IEN = charge_time_pkg::ADDR_INT_ENABLE;
  logic clk;
  logic srst;
  charge_time_pkg::reg_req_t regReq;
  logic [7:0] regRdata;
  logic [3:0] want;
  logic pinOne, pinTwo, tOne, tTwo, irqReq;
  charge_time_pkg::analog_ctl_t analogCtl;
  int errors;
  int checked;
  charge_time_edge_control i_charge_time_edge_control (.clk(clk),
    .srst(srst), .regReq(regReq), .regRdata(regRdata),
    .edgePinOne(pinOne), .edgePinTwo(pinTwo), .trigOne(tOne),
    .trigTwo(tTwo), .analogCtl(analogCtl), .irqReq(irqReq));
  edge_source_model i_edge_source_model (.clk(clk), .want(want),
    .edgePinOne(pinOne), .edgePinTwo(pinTwo), .trigOne(tOne),
    .trigTwo(tTwo));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task end_sim;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_sim
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    regReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    regReq <= '0;
    @(negedge clk);
  endtask : wr
  task rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    regReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    regReq <= '0;
    @(negedge clk);
    chk(regRdata, exp);
  endtask : rd
  // covers the pin synchroniser latency with margin
  task settle;
    repeat (6) @(posedge clk);
    @(negedge clk);
  endtask : settle
  task done(input string n);
    $display("test %s ended", n);
  endtask : done
  initial begin
    #(100 * 3000);
    errors++;
    end_sim();
  end
  initial begin
    srst = 1'b1;
    regReq = '0;
    want = 4'h0;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    rd(CUR, 8'h00);
    rd(CFG, 8'h00);
    rd(MOD, 8'h00);
    chk({7'h0, analogCtl.timeDelayMode}, 8'h00);
    done("reset");
    wr(CUR, 8'h7C);
    rd(CUR, 8'h7C);
    chk({analogCtl.trim, analogCtl.range}, 8'h7C);
    wr(CUR, 8'h82);
    chk({analogCtl.trim, analogCtl.range}, 8'h82);
    rd(4'hF, 8'h00);
    done("registers");
    wr(MOD, 8'h80);
    wr(CFG, 8'h01);
    settle();
    chk({7'h0, analogCtl.currentOn}, 8'h01);
    wr(CFG, 8'h03);
    settle();
    chk({7'h0, analogCtl.currentOn}, 8'h00);
    rd(FLG, 8'h04);
    chk({7'h0, irqReq}, 8'h00);
    wr(IEN, 8'h04);
    settle();
    chk({7'h0, irqReq}, 8'h01);
    rd(CFG, 8'h03);
    wr(FLG, 8'h00);
    settle();
    chk({7'h0, irqReq}, 8'h00);
    wr(CFG, 8'h01);
    wr(MOD, 8'h00);
    settle();
    chk({7'h0, analogCtl.currentOn}, 8'h00);
    rd(CFG, 8'h01);
    done("software");
    wr(MOD, 8'h83);
    settle();
    chk({5'h0, analogCtl.discharge, analogCtl.timeDelayMode,
      analogCtl.toComparatorInput}, 8'h07);
    wr(MOD, 8'h03);
    settle();
    chk({5'h0, analogCtl.discharge, analogCtl.timeDelayMode,
      analogCtl.toComparatorInput}, 8'h02);
    done("mode");
    for (int s = 0; s < 4; s++) begin
      wr(MOD, 8'h80);
      wr(CFG, 8'h10 | 8'(s << 2) | 8'(s << 5));
      want <= 4'h1 << s;
      settle();
      rd(CFG, 8'h10 | 8'(s << 2) | 8'(s << 5));
      wr(MOD, 8'h88);
      settle();
      rd(CFG, 8'h11 | 8'(s << 2) | 8'(s << 5));
      chk({7'h0, analogCtl.currentOn}, 8'h01);
      want <= 4'h0;
    end
    done("sources");
    wr(MOD, 8'h80);
    wr(CFG, 8'h84);
    want <= 4'h2;
    settle();
    wr(MOD, 8'h88);
    settle();
    rd(CFG, 8'h84);
    wr(CFG, 8'h94);
    rd(CFG, 8'h95);
    want <= 4'h0;
    done("match");
    wr(MOD, 8'h80);
    wr(CFG, 8'hF0);
    want <= 4'h8;
    wr(MOD, 8'h8C);
    settle();
    rd(CFG, 8'hF0);
    want <= 4'h9;
    settle();
    rd(CFG, 8'hF3);
    chk({7'h0, analogCtl.currentOn}, 8'h00);
    done("sequence");
    end_sim();
  end
endmodule : charge_time_edge_control_tb_top
